/* File: common/rivm_pkg.sv */
package rivm_pkg;

	localparam int ADDR_W = 16;
	localparam int N_SRC = 25;
	localparam int IDX_W = 5;
	localparam int UNLOCK_CYCLES_DEF = 4;
	localparam int WIN_W = 3;

	// fuse encoding: erased cell reads one
	localparam logic FUSE_UNPROG = 1'h1;

	localparam logic [ADDR_W-1:0] RESET_ADDR_APP = 16'h0000;
	localparam logic [ADDR_W-1:0] TABLE_OFS = 16'h0002;
	localparam int SLOT_SHIFT = 1;
	localparam logic [IDX_W-1:0] FIRST_IRQ_VEC = 5'h02;

	// request bit index equals vector number minus two
	localparam int SRC_EXT0 = 0;
	localparam int SRC_EXT1 = 1;
	localparam int SRC_PCH0 = 2;
	localparam int SRC_WDOG = 5;
	localparam int SRC_TMR2 = 6;
	localparam int SRC_TMR1 = 9;
	localparam int SRC_TMR0 = 13;
	localparam int SRC_SER = 16;
	localparam int SRC_MISC = 20;

	// word address of each entry relative to base address 0 (table start is TABLE_OFS above it), indexed by source bit
	localparam logic [N_SRC-1:0][ADDR_W-1:0] VEC_OFS = {
		16'h0032, 16'h0030, 16'h002E, 16'h002C, 16'h002A,
		16'h0028, 16'h0026, 16'h0024, 16'h0022,
		16'h0020, 16'h001E, 16'h001C,
		16'h001A, 16'h0018, 16'h0016, 16'h0014,
		16'h0012, 16'h0010, 16'h000E,
		16'h000C, 16'h000A, 16'h0008, 16'h0006,
		16'h0004, 16'h0002
	};

	typedef enum logic [1:0] {
		RIVM_IDLE,
		RIVM_OPEN,
		RIVM_TRAIL
	} rivm_phase_t;

	typedef struct packed {
		logic en;
		logic unlock;
		logic relocate;
	} rivm_ctl_wr_t;

	typedef struct packed {
		rivm_phase_t phase;
		logic [WIN_W-1:0] win;
		logic relocate;
		logic fuse_taken;
		logic boot_rst;
		logic [ADDR_W-1:0] boot_addr;
		logic [ADDR_W-1:0] reset_vec;
		logic irq_valid;
		logic [ADDR_W-1:0] vec_addr;
		logic [IDX_W-1:0] vec_num;
		logic blocked;
	} rivm_state_t;

endpackage

/* File: hw/rivm_prio.sv */
`timescale 1ns/1ps
module rivm_prio #(
	parameter int N = 25,
	parameter int W = 5
) (
	input wire logic [N-1:0] req,
	output logic any,
	output logic [W-1:0] idx
);
	generate
		if (N < 1 || N > (1 << W)) begin : g_bad
			$error("rivm_prio: N does not fit index width");
		end
	endgenerate

	// scan downward so the lowest set bit is the last to win
	always_comb begin
		any = |req;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = W'(i);
			end
		end
	end
endmodule // rivm_prio

/* File: hw/rivm_top.sv */
`timescale 1ns/1ps
module rivm_top #(
	parameter int UNLOCK_CYCLES = rivm_pkg::UNLOCK_CYCLES_DEF,
	parameter int N_REQ = rivm_pkg::N_SRC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic boot_reset_fuse,
	input wire logic [rivm_pkg::ADDR_W-1:0] boot_start_addr,
	input wire logic [N_REQ-1:0] irq_req,
	input wire logic global_int_enable,
	input wire rivm_pkg::rivm_ctl_wr_t ctl_wr,
	input wire logic insn_done,
	output logic [rivm_pkg::ADDR_W-1:0] reset_vec_q,
	output logic reset_vec_valid_q,
	output logic irq_valid_q,
	output logic [rivm_pkg::ADDR_W-1:0] irq_vec_addr_q,
	output logic [rivm_pkg::IDX_W-1:0] irq_vec_num_q,
	output logic irq_blocked_q,
	output logic vector_relocate_q
);
	generate
		if (UNLOCK_CYCLES < 1 || UNLOCK_CYCLES >= (1 << rivm_pkg::WIN_W)) begin : g_bad_win
			$error("rivm_top: UNLOCK_CYCLES outside counter range");
		end
		if (N_REQ != rivm_pkg::N_SRC) begin : g_bad_n
			$error("rivm_top: request count must match vector table");
		end
	endgenerate

	rivm_pkg::rivm_state_t q;
	rivm_pkg::rivm_state_t d;
	logic req_any;
	logic [rivm_pkg::IDX_W-1:0] req_idx;
	logic unlock_wr;
	logic sel_wr;
	logic [rivm_pkg::ADDR_W-1:0] tbl_base;

	rivm_prio #(
		.N(N_REQ),
		.W(rivm_pkg::IDX_W)
	) u_prio (
		.req(irq_req),
		.any(req_any),
		.idx(req_idx)
	);

	always_comb begin
		d = q;
		unlock_wr = ctl_wr.en && ctl_wr.unlock;
		sel_wr = ctl_wr.en && !ctl_wr.unlock && (q.phase == rivm_pkg::RIVM_OPEN);
		// table start moves with the relocate bit only, never with the reset vector
		tbl_base = (q.relocate ? q.boot_addr : rivm_pkg::RESET_ADDR_APP)
			+ rivm_pkg::TABLE_OFS;

		// strap sampled once, on the first edge after reset release
		if (!q.fuse_taken) begin
			d.fuse_taken = 1'b1;
			d.boot_rst = boot_reset_fuse;
			d.boot_addr = boot_start_addr;
			if (boot_reset_fuse == rivm_pkg::FUSE_UNPROG) begin
				d.reset_vec = rivm_pkg::RESET_ADDR_APP;
			end else begin
				d.reset_vec = boot_start_addr;
			end
		end

		case (q.phase)
			rivm_pkg::RIVM_IDLE: begin
				d.phase = rivm_pkg::RIVM_IDLE;
			end
			rivm_pkg::RIVM_OPEN: begin
				if (sel_wr) begin
					d.relocate = ctl_wr.relocate;
					d.phase = rivm_pkg::RIVM_TRAIL;
				end else if (q.win == rivm_pkg::WIN_W'(1)) begin
					d.phase = rivm_pkg::RIVM_IDLE;
				end else begin
					d.win = q.win - rivm_pkg::WIN_W'(1);
				end
			end
			rivm_pkg::RIVM_TRAIL: begin
				// hold off until the instruction after the select write retires
				if (insn_done) begin
					d.phase = rivm_pkg::RIVM_IDLE;
				end
			end
			default: begin
				d.phase = rivm_pkg::RIVM_IDLE;
			end
		endcase

		// a repeated unlock restarts the window
		if (unlock_wr) begin
			d.phase = rivm_pkg::RIVM_OPEN;
			d.win = rivm_pkg::WIN_W'(UNLOCK_CYCLES);
		end
		d.blocked = (d.phase != rivm_pkg::RIVM_IDLE);

		// the I-bit is only read here, never written; blocking gates the request
		d.irq_valid = req_any && global_int_enable && q.fuse_taken
			&& (q.phase == rivm_pkg::RIVM_IDLE) && !unlock_wr;
		d.vec_num = req_idx + rivm_pkg::FIRST_IRQ_VEC;
		d.vec_addr = tbl_base
			+ (rivm_pkg::ADDR_W'(req_idx) << rivm_pkg::SLOT_SHIFT);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '{
				phase: rivm_pkg::RIVM_IDLE,
				win: '0,
				relocate: 1'b0,
				fuse_taken: 1'b0,
				boot_rst: 1'b1,
				boot_addr: '0,
				reset_vec: rivm_pkg::RESET_ADDR_APP,
				irq_valid: 1'b0,
				vec_addr: '0,
				vec_num: '0,
				blocked: 1'b0
			};
		end else begin
			q <= d;
		end
	end

	assign reset_vec_q = q.reset_vec;
	assign reset_vec_valid_q = q.fuse_taken;
	assign irq_valid_q = q.irq_valid;
	assign irq_vec_addr_q = q.vec_addr;
	assign irq_vec_num_q = q.vec_num;
	assign irq_blocked_q = q.blocked;
	assign vector_relocate_q = q.relocate;

	// ---------------- checks ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	logic [N_REQ-1:0] lower_mask;
	always_comb begin
		lower_mask = '0;
		for (int i = 0; i < N_REQ; i++) begin
			lower_mask[i] = (i + 2) < int'(q.vec_num);
		end
	end

	property p_slot(int idx);
		irq_valid_q && (irq_vec_num_q == rivm_pkg::IDX_W'(idx + 2))
			|-> irq_vec_addr_q == (vector_relocate_q ? q.boot_addr : rivm_pkg::RESET_ADDR_APP)
				+ rivm_pkg::VEC_OFS[idx];
	endproperty

	sequence s_unlock;
		ctl_wr.en && ctl_wr.unlock;
	endsequence

	sequence s_select;
		ctl_wr.en && !ctl_wr.unlock;
	endsequence

	chk_reset_app_vec: assert property ($rose(reset_vec_valid_q) && q.boot_rst
		|-> reset_vec_q == rivm_pkg::RESET_ADDR_APP)
		else $error("reset vector not zero with fuse unprogrammed");
	chk_reset_boot_vec: assert property ($rose(reset_vec_valid_q) && !q.boot_rst
		|-> reset_vec_q == $past(boot_start_addr) && $past(boot_reset_fuse) == 1'b0)
		else $error("reset vector not boot address with fuse programmed");
	chk_ext_slot: assert property (p_slot(rivm_pkg::SRC_EXT1))
		else $error("external request vector misplaced");
	chk_pin_slot: assert property (p_slot(rivm_pkg::SRC_PCH0))
		else $error("pin change vector misplaced");
	chk_wdog_slot: assert property (p_slot(rivm_pkg::SRC_WDOG))
		else $error("watchdog vector misplaced");
	chk_tmr2_slot: assert property (p_slot(rivm_pkg::SRC_TMR2))
		else $error("timer2 vector misplaced");
	chk_tmr1_slot: assert property (p_slot(rivm_pkg::SRC_TMR1))
		else $error("timer1 vector misplaced");
	chk_tmr0_slot: assert property (p_slot(rivm_pkg::SRC_TMR0))
		else $error("timer0 vector misplaced");
	chk_serial_slot: assert property (p_slot(rivm_pkg::SRC_SER))
		else $error("serial vector misplaced");
	chk_misc_slot: assert property (p_slot(N_REQ - 1))
		else $error("store ready vector misplaced");
	chk_table_base: assert property (irq_valid_q && irq_vec_num_q == rivm_pkg::FIRST_IRQ_VEC
		|-> irq_vec_addr_q == (vector_relocate_q ? q.boot_addr + rivm_pkg::TABLE_OFS
			: rivm_pkg::TABLE_OFS))
		else $error("table start wrong for relocate setting");
	chk_lowest_first: assert property (irq_valid_q
		|-> ($past(irq_req) & lower_mask) == '0
			&& ((($past(irq_req) >> (irq_vec_num_q - rivm_pkg::FIRST_IRQ_VEC))
				& N_REQ'(1)) != '0))
		else $error("higher vector served before lower pending one");
	chk_idle_no_req: assert property (irq_req == '0 |=> !irq_valid_q)
		else $error("vector issued with no request");
	chk_block_unlock: assert property (s_unlock |=> !irq_valid_q && irq_blocked_q)
		else $error("interrupt taken during change sequence");
	chk_window_close: assert property (s_unlock ##1 (!ctl_wr.en) [*4]
		|=> !irq_blocked_q)
		else $error("change window not closed after four cycles");
	chk_relocate_late: assert property (s_select and (q.phase != rivm_pkg::RIVM_OPEN)
		|=> $stable(vector_relocate_q))
		else $error("relocate changed without unlock");
	chk_relocate_take: assert property (s_unlock ##1 (s_select and !unlock_wr)
		|=> vector_relocate_q == $past(ctl_wr.relocate) && irq_blocked_q)
		else $error("relocate write inside window not taken");

endmodule // rivm_top

/* File: sim/rivm_core_model.sv */
`timescale 1ns/1ps
module rivm_core_model (
	input wire logic clk,
	output rivm_pkg::rivm_ctl_wr_t ctl_wr,
	output logic insn_done
);
	initial begin
		ctl_wr = '0;
		insn_done = 1'b0;
	end

	// one-cycle store to the control register; idle lines show the inverse so stale bits never pass
	task automatic ctl(input logic unlock, input logic relocate);
		@(negedge clk);
		ctl_wr = '{en: 1'b1, unlock: unlock, relocate: relocate};
		@(negedge clk);
		ctl_wr = '{en: 1'b0, unlock: ~unlock, relocate: ~relocate};
	endtask

	// unlock and select on consecutive edges, the tightest legal spacing
	task automatic unlock_select(input logic relocate);
		@(negedge clk);
		ctl_wr = '{en: 1'b1, unlock: 1'b1, relocate: ~relocate};
		@(negedge clk);
		ctl_wr = '{en: 1'b1, unlock: 1'b0, relocate: relocate};
		@(negedge clk);
		ctl_wr = '{en: 1'b0, unlock: 1'b1, relocate: ~relocate};
	endtask

	task automatic retire();
		@(negedge clk);
		insn_done = 1'b1;
		@(negedge clk);
		insn_done = 1'b0;
	endtask
endmodule // rivm_core_model

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
	localparam logic [15:0] BOOT = 16'h3C00;
	logic clk, resetn, fuse, ie, insn_done, rvalid, ivalid, blocked, reloc;
	logic [24:0] req;
	logic [15:0] boot, rvec, vaddr;
	logic [4:0] vnum;
	rivm_pkg::rivm_ctl_wr_t ctl_wr;
	int failures, n_checks;

	rivm_top DUT (
		.clk(clk), .resetn(resetn), .boot_reset_fuse(fuse), .boot_start_addr(boot),
		.irq_req(req), .global_int_enable(ie), .ctl_wr(ctl_wr), .insn_done(insn_done),
		.reset_vec_q(rvec), .reset_vec_valid_q(rvalid), .irq_valid_q(ivalid),
		.irq_vec_addr_q(vaddr), .irq_vec_num_q(vnum), .irq_blocked_q(blocked),
		.vector_relocate_q(reloc)
	);
	rivm_core_model core (.clk(clk), .ctl_wr(ctl_wr), .insn_done(insn_done));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic t_reset_vec(input logic f);
		@(negedge clk);
		resetn = 1'b0;
		fuse = f;
		req = '0;
		cyc(5);
		resetn = 1'b1;
		cyc(2);
		check("reset_vec", rvec, f ? 16'h0000 : BOOT);
		check("reset_valid", {15'h0, rvalid}, 16'h0001);
		check("relocate_rst", {15'h0, reloc}, 16'h0000);
		check("idle_valid", {15'h0, ivalid}, 16'h0000);
	endtask

	// every source alone, slot of two words per vector
	task automatic t_table(input logic [15:0] base);
		for (int i = 0; i < 25; i++) begin
			req = 25'h0000001 << i;
			cyc(2);
			check("vec_valid", {15'h0, ivalid}, 16'h0001);
			check("vec_addr", vaddr, base + 16'(2 * i));
			check("vec_num", {11'h0, vnum}, 16'(i + 2));
		end
		req = '0;
		cyc(1);
	endtask

	task automatic t_prio();
		req = 25'h10000A0;
		cyc(2);
		check("prio_num", {11'h0, vnum}, 16'h0007);
		check("prio_addr", vaddr, 16'h000C);
		ie = 1'b0;
		cyc(2);
		check("ibit_off", {15'h0, ivalid}, 16'h0000);
		ie = 1'b1;
		req = '0;
		cyc(2);
		check("no_req", {15'h0, ivalid}, 16'h0000);
	endtask

	task automatic t_relocate();
		req = 25'h0000001;
		core.ctl(1'b1, 1'b0);
		core.ctl(1'b0, 1'b1);
		check("blk_open", {15'h0, blocked}, 16'h0001);
		check("blk_valid", {15'h0, ivalid}, 16'h0000);
		cyc(1);
		check("reloc_set", {15'h0, reloc}, 16'h0001);
		check("blk_trail", {15'h0, blocked}, 16'h0001);
		core.retire();
		cyc(2);
		check("blk_end", {15'h0, blocked}, 16'h0000);
		cyc(2);
		check("reloc_addr", vaddr, BOOT + 16'h0002);
		req = '0;
		cyc(1);
	endtask

	task automatic t_nowrite();
		req = 25'h0000001;
		core.ctl(1'b1, 1'b0);
		cyc(1);
		check("nw_blk", {15'h0, blocked}, 16'h0001);
		cyc(5);
		check("nw_release", {15'h0, blocked}, 16'h0000);
		core.ctl(1'b0, 1'b0);
		cyc(2);
		check("late_write", {15'h0, reloc}, 16'h0001);
		check("nw_valid", {15'h0, ivalid}, 16'h0001);
		req = '0;
		cyc(1);
	endtask

	// select on the edge right after unlock, moving the table back to the application side
	task automatic t_backtoback();
		req = 25'h0000001;
		core.unlock_select(1'b0);
		check("bb_reloc", {15'h0, reloc}, 16'h0000);
		check("bb_blk", {15'h0, blocked}, 16'h0001);
		core.retire();
		cyc(2);
		check("bb_end", {15'h0, blocked}, 16'h0000);
		check("bb_valid", {15'h0, ivalid}, 16'h0001);
		check("bb_addr", vaddr, 16'h0002);
		req = '0;
	endtask

	initial begin
		failures = 0;
		n_checks = 0;
		resetn = 1'b0;
		fuse = 1'b1;
		ie = 1'b1;
		req = '0;
		boot = BOOT;
		t_reset_vec(1'b1);
		t_table(16'h0002);
		t_prio();
		t_relocate();
		t_table(BOOT + 16'h0002);
		t_nowrite();
		t_backtoback();
		t_reset_vec(1'b0);
		t_table(16'h0002);
		stop_test();
	end

	// whole run is some 200 cycles
	initial begin
		#(2000 * 100);
		failures++;
		stop_test();
	end
endmodule // testbench
